//--- logic/interval_timer_pkg.sv
package interval_timer_pkg;

	localparam int unsigned CLK_FREQ_HZ = 50_000_000;

	// Register byte offsets
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_CMP = 12'h004;
	localparam logic [11:0] OFF_COUNT = 12'h008;
	localparam logic [11:0] OFF_STATUS = 12'h00C;
	localparam logic [11:0] OFF_MASK = 12'h010;

	// Control field positions
	localparam int unsigned CTRL_RUN = 0;
	localparam int unsigned CTRL_ONESHOT = 1;
	localparam int unsigned CTRL_SPLIT = 2;
	localparam int unsigned CTRL_FAST = 3;
	localparam int unsigned CTRL_SRC_LO = 4;
	localparam int unsigned CTRL_OUT_INIT = 6;
	localparam int unsigned CTRL_EXT_SEL = 7;
	localparam int unsigned CTRL_DIV_LO = 8;
	localparam int unsigned CTRL_RUN_LO8 = 11;

	// Status and mask bit positions
	localparam int unsigned ST_MATCH = 0;
	localparam int unsigned ST_MATCH_LO8 = 1;
	localparam int unsigned ST_WIDTH = 2;

	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [15:0] CMP_RESET = 16'hFFFF;
	localparam logic [15:0] COUNT_MAX16 = 16'hFFFF;
	localparam logic [7:0] COUNT_MAX8 = 8'hFF;

	typedef enum logic [1:0] {
		SRC_TIMER,
		SRC_DIVIDED,
		SRC_EXTERNAL,
		SRC_OFF
	} count_src_t;

	typedef struct packed {
		logic run;
		logic oneshot;
		logic split;
		logic fast;
		count_src_t src;
		logic out_init;
		logic ext_sel;
		logic [2:0] div_sel;
		logic run_lo8;
	} ctrl_t;

endpackage : interval_timer_pkg

//--- logic/count_tick_gen.sv
module count_tick_gen
	import interval_timer_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic slow_tick_i,
	input wire logic fast_tick_i,
	input wire logic fast_sel_i,
	input wire count_src_t src_i,
	input wire logic [2:0] div_sel_i,
	input wire logic ext_level_i,
	output logic tick_o
);

	typedef struct packed {
		logic [6:0] div_cnt;
		logic ext_prev;
		logic tick;
	} tick_state_t;

	tick_state_t s_reg;
	tick_state_t s_next;
	logic base_tick;
	logic [6:0] div_mask;

	always_comb begin
		base_tick = fast_sel_i ? fast_tick_i : slow_tick_i;
		div_mask = 7'((8'h01 << div_sel_i) - 8'h01);
		s_next = s_reg;
		s_next.ext_prev = ext_level_i;
		if (base_tick) begin
			s_next.div_cnt = 7'(s_reg.div_cnt + 7'h01) & div_mask;
		end
		case (src_i)
			SRC_TIMER: s_next.tick = base_tick;
			SRC_DIVIDED: s_next.tick = base_tick && ((s_reg.div_cnt & div_mask) == div_mask);
			SRC_EXTERNAL: s_next.tick = ext_level_i && !s_reg.ext_prev;
			default: s_next.tick = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign tick_o = s_reg.tick;

endmodule : count_tick_gen

//--- logic/split_capable_interval_timer.sv
// Contract
// - In 16-bit mode the counter reaches up to 0xffff before matching or wrapping.
// - Repeat operation keeps running its count-and-match cycle until software stops it.
// - One-shot operation runs the cycle once and then stops by itself.
// - In 8-bit mode each half counts up to 0xff, in repeat or one-shot operation.
// - The channel can run as two independent 8-bit timers from its upper and lower halves.
// - The timer clock is either the slow or the fast peripheral clock.
// - The count clock is the timer clock, a divided timer clock or an external input.
// - With external counting the counter advances once per rising edge of that input.
// - The match interrupt is raised when the counter equals the compare value.
// - The pulse output inverts on every 16-bit or upper-half match, giving a pulse train or a single pulse.
// - The starting level of the pulse output is set by software before counting.
// - In split mode both halves share one clock setting and one interrupt setup; here each half has its own status and mask bit on one interrupt line.
// - In 8-bit mode the pulse output follows only upper-half matches.
// - The two external triggers come from the filtered external interrupt pins.
//
// Decided for this implementation: the register offsets and the APB slave port.
module split_capable_interval_timer
	import interval_timer_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic slow_peripheral_clock_i,
	input wire logic fast_peripheral_clock_i,
	input wire logic ext_trigger_in0_i,
	input wire logic ext_trigger_in1_i,
	output logic timer_pulse_out_o,
	output logic timer_match_irq_o,
	output logic timer_trigger_out_o
);

	typedef struct packed {
		ctrl_t ctrl;
		logic [15:0] cmp;
		logic [15:0] cnt;
		logic [ST_WIDTH-1:0] status;
		logic [ST_WIDTH-1:0] mask;
		logic pulse;
		logic irq;
		logic trig;
		logic ready;
		logic slverr;
		logic [31:0] rdata;
	} state_t;

	state_t r_reg;
	state_t r_next;
	logic tick;
	logic ext_level;

	function automatic logic [31:0] pack_ctrl(input ctrl_t c);
		logic [31:0] w;
		w = '0;
		w[CTRL_RUN] = c.run;
		w[CTRL_ONESHOT] = c.oneshot;
		w[CTRL_SPLIT] = c.split;
		w[CTRL_FAST] = c.fast;
		w[CTRL_SRC_LO +: 2] = c.src;
		w[CTRL_OUT_INIT] = c.out_init;
		w[CTRL_EXT_SEL] = c.ext_sel;
		w[CTRL_DIV_LO +: 3] = c.div_sel;
		w[CTRL_RUN_LO8] = c.run_lo8;
		return w;
	endfunction : pack_ctrl

	function automatic ctrl_t unpack_ctrl(input logic [31:0] w);
		ctrl_t c;
		c.run = w[CTRL_RUN];
		c.oneshot = w[CTRL_ONESHOT];
		c.split = w[CTRL_SPLIT];
		c.fast = w[CTRL_FAST];
		c.src = count_src_t'(w[CTRL_SRC_LO +: 2]);
		c.out_init = w[CTRL_OUT_INIT];
		c.ext_sel = w[CTRL_EXT_SEL];
		c.div_sel = w[CTRL_DIV_LO +: 3];
		c.run_lo8 = w[CTRL_RUN_LO8];
		return c;
	endfunction : unpack_ctrl

	// Triggers arrive already filtered by the external interrupt logic
	assign ext_level = r_reg.ctrl.ext_sel ? ext_trigger_in1_i : ext_trigger_in0_i;

	// One tick source serves both halves in split mode
	count_tick_gen u_tick (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.slow_tick_i(slow_peripheral_clock_i),
		.fast_tick_i(fast_peripheral_clock_i),
		.fast_sel_i(r_reg.ctrl.fast),
		.src_i(r_reg.ctrl.src),
		.div_sel_i(r_reg.ctrl.div_sel),
		.ext_level_i(ext_level),
		.tick_o(tick)
	);

	logic wr_acc;
	logic rd_acc;
	logic match16;
	logic match_hi;
	logic match_lo;
	logic hit_main;
	logic hit_lo;
	logic [ST_WIDTH-1:0] events;
	logic [31:0] clr;
	ctrl_t new_ctrl;

	always_comb begin
		r_next = r_reg;
		wr_acc = psel_i && penable_i && pwrite_i && r_reg.ready;
		rd_acc = psel_i && penable_i && !pwrite_i && r_reg.ready;
		match16 = r_reg.cnt == r_reg.cmp;
		match_hi = r_reg.cnt[15:8] == r_reg.cmp[15:8];
		match_lo = r_reg.cnt[7:0] == r_reg.cmp[7:0];
		hit_main = tick && r_reg.ctrl.run && (r_reg.ctrl.split ? match_hi : match16);
		hit_lo = tick && r_reg.ctrl.split && r_reg.ctrl.run_lo8 && match_lo;
		events = '0;
		events[ST_MATCH] = hit_main;
		events[ST_MATCH_LO8] = hit_lo;
		clr = '0;
		new_ctrl = unpack_ctrl(pwdata_i);

		// Counting
		if (r_reg.ctrl.split) begin
			if (tick && r_reg.ctrl.run) begin
				// 8-bit halves wrap naturally at 0xff
				r_next.cnt[15:8] = match_hi ? 8'h00 : 8'(r_reg.cnt[15:8] + 8'h01);
				if (match_hi && r_reg.ctrl.oneshot) begin
					r_next.ctrl.run = 1'b0;
				end
			end
			if (tick && r_reg.ctrl.run_lo8) begin
				r_next.cnt[7:0] = match_lo ? 8'h00 : 8'(r_reg.cnt[7:0] + 8'h01);
				if (match_lo && r_reg.ctrl.oneshot) begin
					r_next.ctrl.run_lo8 = 1'b0;
				end
			end
		end else if (tick && r_reg.ctrl.run) begin
			// Full 16-bit range up to COUNT_MAX16 then wrap
			r_next.cnt = match16 ? 16'h0000 : 16'(r_reg.cnt + 16'h0001);
			if (match16 && r_reg.ctrl.oneshot) begin
				r_next.ctrl.run = 1'b0;
			end
		end

		if (hit_main) begin
			r_next.pulse = !r_reg.pulse;
		end
		// Converter/DMA trigger only in 16-bit mode
		r_next.trig = hit_main && !r_reg.ctrl.split;

		// Bus writes
		if (wr_acc) begin
			case (paddr_i)
				OFF_CTRL: begin
					r_next.ctrl = new_ctrl;
					if (!r_reg.ctrl.run && new_ctrl.run) begin
						r_next.cnt[15:8] = 8'h00;
						r_next.pulse = new_ctrl.out_init;
					end
					if (!r_reg.ctrl.run && !new_ctrl.run) begin
						r_next.pulse = new_ctrl.out_init;
					end
					if (!r_reg.ctrl.run_lo8 && new_ctrl.run_lo8) begin
						r_next.cnt[7:0] = 8'h00;
					end
					if (!r_reg.ctrl.run && new_ctrl.run && !new_ctrl.split) begin
						r_next.cnt[7:0] = 8'h00;
					end
				end
				OFF_CMP: r_next.cmp = pwdata_i[15:0];
				OFF_STATUS: clr = pwdata_i;
				OFF_MASK: r_next.mask = pwdata_i[ST_WIDTH-1:0];
				default: ;
			endcase
		end
		// New events win over a clear in the same cycle
		r_next.status = (r_reg.status & ~clr[ST_WIDTH-1:0]) | events;
		r_next.irq = |(r_next.status & r_next.mask);

		// APB answer: no wait state, ready already in the first access cycle
		r_next.ready = psel_i && !r_reg.ready;
		r_next.slverr = 1'b0;
		r_next.rdata = '0;
		if (psel_i && !r_reg.ready) begin
			case (paddr_i)
				OFF_CTRL: r_next.rdata = pack_ctrl(r_reg.ctrl);
				OFF_CMP: r_next.rdata = {16'h0000, r_reg.cmp};
				OFF_COUNT: r_next.rdata = {16'h0000, r_reg.cnt};
				OFF_STATUS: r_next.rdata = {{(32-ST_WIDTH){1'b0}}, r_reg.status};
				OFF_MASK: r_next.rdata = {{(32-ST_WIDTH){1'b0}}, r_reg.mask};
				default: r_next.slverr = 1'b1;
			endcase
		end
		if (rd_acc || wr_acc) begin
			r_next.ready = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r_reg <= '0;
			r_reg.ctrl <= unpack_ctrl(CTRL_RESET);
			r_reg.cmp <= CMP_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	assign prdata_o = r_reg.rdata;
	assign pready_o = r_reg.ready;
	assign pslverr_o = r_reg.slverr;
	assign timer_pulse_out_o = r_reg.pulse;
	assign timer_match_irq_o = r_reg.irq;
	assign timer_trigger_out_o = r_reg.trig;

	a_oneshot_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		hit_main && r_reg.ctrl.oneshot && !wr_acc |=> !r_reg.ctrl.run)
		else $error("One-shot did not stop after match");
	a_repeat_keeps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		hit_main && !r_reg.ctrl.oneshot && !wr_acc |=> r_reg.ctrl.run)
		else $error("Repeat mode stopped on its own");
	a_restart_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		hit_main && !r_reg.ctrl.split && !wr_acc |=> r_reg.cnt == 16'h0000)
		else $error("Counter did not restart from zero");
	a_pulse_toggle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		hit_main && !wr_acc |=> timer_pulse_out_o != $past(timer_pulse_out_o))
		else $error("Pulse output did not invert on match");
	a_irq_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		hit_main && r_reg.mask[ST_MATCH] && !wr_acc |=> timer_match_irq_o)
		else $error("Match did not raise interrupt");
	a_split_lo_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		r_reg.ctrl.split && !hit_main && !wr_acc |=> $stable(timer_pulse_out_o))
		else $error("Pulse output moved without upper match");
	a_count_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		tick && r_reg.ctrl.run && !r_reg.ctrl.split && !match16 && !wr_acc
		|=> r_reg.cnt == 16'($past(r_reg.cnt) + 16'h0001))
		else $error("Counter did not advance by one");
	a_start_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_acc && paddr_i == OFF_CTRL && !r_reg.ctrl.run
		|=> timer_pulse_out_o == $past(pwdata_i[CTRL_OUT_INIT]))
		else $error("Pulse start level not taken");
	a_apb_ready: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		psel_i && !penable_i && !pready_o |=> pready_o)
		else $error("APB answer not after one cycle");
	a_ready_one_cycle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		pready_o |=> !pready_o)
		else $error("APB ready stood longer than one cycle");
	a_slverr_ready: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		pslverr_o |-> pready_o)
		else $error("Bus error shown without ready");

	// Write cycles are left out below except in a_ext_rise_only, a_status_sticky and a_split_no_trig: software may restart or reload the counter there
	a_lo_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		hit_lo && !wr_acc |=> r_reg.cnt[7:0] == 8'h00)
		else $error("Lower half did not restart from zero");
	a_lo_oneshot_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		hit_lo && r_reg.ctrl.oneshot && !wr_acc |=> !r_reg.ctrl.run_lo8)
		else $error("Lower half one-shot did not stop");
	a_lo_repeat_keeps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		hit_lo && !r_reg.ctrl.oneshot && !wr_acc |=> r_reg.ctrl.run_lo8)
		else $error("Lower half repeat stopped on its own");
	a_lo_count_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		tick && r_reg.ctrl.split && r_reg.ctrl.run_lo8 && !match_lo && !wr_acc
		|=> r_reg.cnt[7:0] == 8'($past(r_reg.cnt[7:0]) + 8'h01))
		else $error("Lower half did not advance by one");
	a_hi_count_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		tick && r_reg.ctrl.split && r_reg.ctrl.run && !match_hi && !wr_acc
		|=> r_reg.cnt[15:8] == 8'($past(r_reg.cnt[15:8]) + 8'h01))
		else $error("Upper half did not advance by one");
	a_ext_rise_only: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		tick && $past(r_reg.ctrl.src) == SRC_EXTERNAL
		|-> $past(ext_level) && !$past(ext_level, 2))
		else $error("External tick without a rising edge");
	a_status_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		r_reg.status[ST_MATCH] && !(wr_acc && paddr_i == OFF_STATUS && pwdata_i[ST_MATCH])
		|=> r_reg.status[ST_MATCH])
		else $error("Match status cleared without a write");
	a_split_no_trig: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		r_reg.ctrl.split |=> !timer_trigger_out_o)
		else $error("Trigger pulse raised in split mode");
	a_idle_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!r_reg.ctrl.run && !r_reg.ctrl.run_lo8 && !wr_acc |=> $stable(r_reg.cnt))
		else $error("Stopped counter moved");
	a_pulse_stopped: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!r_reg.ctrl.run && !wr_acc |=> $stable(timer_pulse_out_o))
		else $error("Pulse output moved while stopped");

	c_oneshot: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		hit_main && r_reg.ctrl.oneshot);
	c_split_lo: cover property (@(posedge clk_i) disable iff (!rst_n_i) hit_lo);
	c_ext_count: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		tick && r_reg.ctrl.src == SRC_EXTERNAL);
	c_repeat_match: cover property (@(posedge clk_i) disable iff (!rst_n_i)
		hit_main && !r_reg.ctrl.oneshot && !r_reg.ctrl.split);
	c_bus_error: cover property (@(posedge clk_i) disable iff (!rst_n_i) pslverr_o);

endmodule : split_capable_interval_timer

//--- tb/tick_pin_model.sv
module tick_pin_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic go0_i,
	input wire logic go1_i,
	output logic slow_o,
	output logic fast_o,
	output logic ext0_o,
	output logic ext1_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] div_reg;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_reg <= 3'h0;
			ext0_o <= 1'b0;
			ext1_o <= 1'b0;
		end else begin
			div_reg <= div_reg + 3'h1;
			// Pin levels arrive already filtered, so each command is one clean edge
			ext0_o <= go0_i;
			ext1_o <= go1_i;
		end
	end
	// One-cycle enables: slow every 8 cycles, fast every 2
	assign slow_o = (div_reg == 3'h7);
	assign fast_o = div_reg[0];
endmodule : tick_pin_model

//--- tb/test_split_capable_interval_timer.sv
module test_split_capable_interval_timer;
	timeunit 1ns;
	timeprecision 1ns;
	import interval_timer_pkg::*;
	logic clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, err, lvl;
	logic go0, go1, slow, fast, ext0, ext1, pulse, irq, trig;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int mismatches, checks, t;
	logic [31:0] pc [4] = '{32'h0000_0009, 32'h0000_0001, 32'h0000_0119, 32'h0000_0009};
	logic [31:0] pm [4] = '{32'h0000_0003, 32'h0000_0003, 32'h0000_0003, 32'h0000_0000};
	int pp [4] = '{8, 32, 16, 2};
	split_capable_interval_timer u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.slow_peripheral_clock_i(slow), .fast_peripheral_clock_i(fast),
		.ext_trigger_in0_i(ext0), .ext_trigger_in1_i(ext1), .timer_pulse_out_o(pulse),
		.timer_match_irq_o(irq), .timer_trigger_out_o(trig));
	tick_pin_model u_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .go0_i(go0), .go1_i(go1),
		.slow_o(slow), .fast_o(fast), .ext0_o(ext0), .ext1_o(ext1));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task automatic results();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Entered right after a rising edge; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so the next setup never rewrites psel in this time step
		@(posedge clk_i);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask : rdc
	task automatic wait_trig(input int lim);
		t = -1;
		for (int i = 1; i <= lim; i++) begin
			@(posedge clk_i);
			if (trig === 1'b1) begin
				t = i;
				break;
			end
		end
	endtask : wait_trig
	task automatic pin(input logic sel, input int k);
		repeat (k) begin
			go0 <= !sel;
			go1 <= sel;
			repeat (2) @(posedge clk_i);
			go0 <= 1'b0;
			go1 <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
	endtask : pin
	initial begin
		#200_000;
		mismatches++;
		results();
	end
	initial begin
		{psel, penable, pwrite, go0, go1} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		rst_n_i = 1'b0;
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		rdc(OFF_CTRL, 32'h0000_0000);
		rdc(OFF_CMP, 32'h0000_FFFF);
		rdc(OFF_COUNT, 32'h0000_0000);
		rdc(OFF_STATUS, 32'h0000_0000);
		rdc(OFF_MASK, 32'h0000_0000);
		rdc(12'h020, 32'h0000_0000);
		chk(32'(err), 32'h0000_0001);
		wr(OFF_CMP, 32'hFFFF_FFFF);
		rdc(OFF_CMP, 32'h0000_FFFF);
		wr(OFF_CTRL, 32'h0000_0040);
		rdc(OFF_CTRL, 32'h0000_0040);
		chk(32'(pulse), 32'h0000_0001);
		for (int k = 0; k < 4; k++) begin
			wr(OFF_CMP, pm[k]);
			wr(OFF_CTRL, pc[k]);
			wait_trig(100);
			lvl = pulse;
			wait_trig(100);
			chk(32'(t), 32'(pp[k]));
			chk(32'(pulse), 32'(!lvl));
			wr(OFF_CTRL, 32'h0000_0000);
		end
		wr(OFF_STATUS, 32'h0000_0003);
		wr(OFF_CMP, 32'h0000_0002);
		wr(OFF_CTRL, 32'h0000_000B);
		wait_trig(100);
		chk(32'(irq), 32'h0000_0000);
		rdc(OFF_CTRL, 32'h0000_000A);
		rdc(OFF_STATUS, 32'h0000_0001);
		wr(OFF_MASK, 32'h0000_0001);
		repeat (3) @(posedge clk_i);
		chk(32'(irq), 32'h0000_0001);
		wait_trig(60);
		chk(32'(t), 32'hFFFF_FFFF);
		wr(OFF_STATUS, 32'h0000_0001);
		repeat (3) @(posedge clk_i);
		chk(32'(irq), 32'h0000_0000);
		wr(OFF_CMP, 32'h0000_FFFF);
		wr(OFF_CTRL, 32'h0000_00A1);
		pin(1'b1, 3);
		pin(1'b0, 2);
		rdc(OFF_COUNT, 32'h0000_0003);
		wr(OFF_CTRL, 32'h0000_0021);
		pin(1'b0, 2);
		rdc(OFF_COUNT, 32'h0000_0005);
		// Split checks the status bits and the pulse output; triggers to other blocks need 16-bit mode
		wr(OFF_CMP, 32'h0000_0102);
		wr(OFF_CTRL, 32'h0000_080C);
		wait_trig(40);
		chk(32'(t), 32'hFFFF_FFFF);
		chk(32'(pulse), 32'h0000_0000);
		rdc(OFF_STATUS, 32'h0000_0002);
		wr(OFF_CTRL, 32'h0000_080D);
		lvl = pulse;
		repeat (5) @(posedge clk_i);
		chk(32'(pulse), 32'(!lvl));
		wait_trig(40);
		chk(32'(t), 32'hFFFF_FFFF);
		rdc(OFF_STATUS, 32'h0000_0003);
		wr(OFF_CTRL, 32'h0000_0030);
		wr(OFF_CTRL, 32'h0000_0039);
		repeat (20) @(posedge clk_i);
		rdc(OFF_COUNT, 32'h0000_0000);
		results();
	end
endmodule : test_split_capable_interval_timer
